// *** rtl/msr_map.svh ***
// Register map, field positions and timing for the sensor readout block
`ifndef MSR_MAP_SVH
`define MSR_MAP_SVH
// ==========================================
// Register offsets (8-bit register pointer)
`define MSR_REG_CTRL 8'h27
`define MSR_REG_UP   8'h28
`define MSR_REG_LO   8'h29
// ==========================================
// Field positions
`define MSR_F_LPCNT  6:4
`define MSR_F_LOOP   3:2
`define MSR_F_MODE   1:0
`define MSR_B_NEW    7
`define MSR_B_INT    6
`define MSR_B_WIP    20
`define MSR_CTRL_RST 7'h00
// ==========================================
// Timing
`define MSR_CLK_MHZ   250
`define MSR_T_TEMP_MS 8
`define MSR_T_POD_US  1000
`define MSR_LP_TDIV   4'hA
`endif

// *** rtl/msr_pkg.sv ***
// Types shared by the sensor readout block
`default_nettype none
package msr_pkg;
  typedef enum logic [1:0] {
    MD_ACTIVE, MD_SLEEP, MD_DUTY, MD_UNDEF
  } msr_mode_t;
  typedef enum {SQ_POD, SQ_MEAS, SQ_WAIT, SQ_IDLE, SQ_SLEEP} msr_seq_t;
  typedef enum {I_IDLE, I_ADDR, I_AACK, I_REG, I_RACK, I_WR, I_WACK,
                I_RD, I_MACK} msr_i2c_t;
endpackage
`default_nettype wire

// *** rtl/msr_readout.sv ***
// Sensor readout: two-wire register slave, data registers, mode sequencer
// Function
// R1 - Reads allowed without access code
// R2 - Writes need access, except mode field
// R3 - Ctrl 6:4 inactive period select
// R4 - Ctrl 3:2 readback loop mode
// R5 - Upper data word packs MSBs, temp
// R6 - New-data flag, cleared by read
// R7 - Interrupt flag, latched, write-one clears
// R8 - Non-volatile write busy flag
// R9 - Lower data word packs LSBs, temp
// R10 - Hall mode tag in 7:6
// R11 - Axis values twelve-bit two's complement
// R12 - Burst halves from same sample
// R13 - Temperature is raw twelve-bit code
// R14 - Temperature refreshed every 8 ms
// R15 - Duty mode temperature every 10 cycles
// R16 - Ctrl 1:0 selects operating mode
// R17 - Sleep answers bus, stops updates
// R18 - Sleep exit waits power-on delay
// R19 - Duty mode alternates measure, inactive
// R20 - Eight inactive durations 0.5..1000 ms
// R21 - Latched interrupt holds output
// R22 - Mode 3 behaves as active
`timescale 1ns/1ps
`default_nettype none
`include "msr_map.svh"
module msr_readout #(
  parameter logic [6:0]  DEV_ADDR   = 7'h60,   // Bus address, arbitrary
  parameter int unsigned CYC_PER_US = `MSR_CLK_MHZ,
  parameter int unsigned TEMP_CYC   = `MSR_T_TEMP_MS * 1000 * `MSR_CLK_MHZ,
  parameter int unsigned POD_CYC    = `MSR_T_POD_US * `MSR_CLK_MHZ
) (
  input  wire logic        CORE_CLK,     // Core clock
  input  wire logic        RST,          // Sync reset, high
  input  wire logic        SCL_I,        // Bus clock pin
  input  wire logic        SDA_I,        // Bus data pin in
  output logic             SDA_O,        // Bus data out, always low
  output logic             SDA_OE,       // Pull data low
  input  wire logic        CUST_ACCESS,  // Access mode active
  input  wire logic        INT_LATCH_EN, // Latch interrupt
  input  wire logic        INT_EE_EN,    // Store interrupt in NVM
  input  wire logic        THRESH_HIT,   // Threshold crossed
  input  wire logic        EE_DONE,      // NVM write finished
  output logic             EE_WR,        // NVM write start pulse
  output logic             INT_N,        // Interrupt out, low
  output logic             MEAS_REQ,     // Start one XYZ sample
  input  wire logic        SAMPLE_VLD,   // Sample ready pulse
  input  wire logic [11:0] X_IN,         // X sample
  input  wire logic [11:0] Y_IN,         // Y sample
  input  wire logic [11:0] Z_IN,         // Z sample
  input  wire logic [1:0]  HALL_IN,      // Hall mode of sample
  output logic             TEMP_REQ,     // Start temperature sample
  input  wire logic        TEMP_VLD,     // Temperature ready pulse
  input  wire logic [11:0] TEMP_IN,      // Temperature code
  output logic [1:0]       MODE          // Effective mode
);

  // ==========================================
  // Pin synchronisers
  logic [2:0] scl_s_q, scl_s_d, sda_s_q, sda_s_d;
  logic       scl_f_q, scl_f_d, sda_f_q, sda_f_d, scl_p_q, sda_p_q;
  logic       rise, fall, start, stop;

  // Level accepted once stages two and three agree
  always_comb begin
    scl_s_d = {scl_s_q[1:0], SCL_I};
    sda_s_d = {sda_s_q[1:0], SDA_I};
    scl_f_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
    sda_f_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
      scl_f_q <= scl_f_d;
      sda_f_q <= sda_f_d;
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  // Bus events
  assign rise  = scl_f_q & ~scl_p_q;
  assign fall  = ~scl_f_q & scl_p_q;
  assign start = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  assign stop  = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

  // ==========================================
  // Register state
  logic [6:0]  ctrl_q, ctrl_d;
  logic [11:0] x_q, x_d, y_q, y_d, z_q, z_d, t_q, t_d;
  logic [1:0]  hall_q, hall_d;
  logic        new_q, new_d, int_q, int_d, wip_q, wip_d, hit_p_q;
  logic [63:0] snap_q, snap_d;
  logic        snap_ok_q, snap_ok_d;
  logic [31:0] up_w, lo_w, rd_w;
  logic        sleep, duty, cap, wr_ctrl, w1c, frozen;
  logic [31:0] wr_w;

  // R16 mode decode
  // R22 undefined mode as active
  assign sleep = (msr_pkg::msr_mode_t'(ctrl_q[`MSR_F_MODE]) == msr_pkg::MD_SLEEP);
  assign duty  = (msr_pkg::msr_mode_t'(ctrl_q[`MSR_F_MODE]) == msr_pkg::MD_DUTY);
  assign MODE  = (sleep | duty) ? ctrl_q[`MSR_F_MODE] : 2'h0;

  // R5 upper word; R11 MSBs are bits 11:4; R13 raw code
  assign up_w = {x_q[11:4], y_q[11:4], z_q[11:4], new_q, int_q, t_q[11:6]};
  // R9 lower word; R8 busy; R10 hall tag
  assign lo_w = {11'h000, wip_q, x_q[3:0], y_q[3:0], z_q[3:0], hall_q, t_q[5:0]};

  // ==========================================
  // Two-wire slave
  msr_pkg::msr_i2c_t st_q, st_d;
  logic [3:0] bc_q, bc_d;
  logic [1:0] bi_q, bi_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d;
  logic [31:0] wb_q, wb_d;
  logic       oe_q, oe_d, rd_q, rd_d, nak_q, nak_d, commit;

  // R4 next pointer; loops fold lower word back to upper
  function automatic logic [7:0] nxt_ptr(input logic [7:0] p,
                                         input logic [1:0] lp);
    if (lp != 2'h0 && p == `MSR_REG_LO) nxt_ptr = `MSR_REG_UP;
    else nxt_ptr = p + 8'h01;
  endfunction

  // R1 reads need no access mode
  // R12 lower word served from burst snapshot
  always_comb begin
    unique case (ptr_q)
      `MSR_REG_CTRL: rd_w = {25'h0, ctrl_q};
      // Later upper bytes from the snapshot, else the new flag reads cleared
      `MSR_REG_UP:   rd_w = (snap_ok_q && bi_q != 2'h0) ? snap_q[63:32] : up_w;
      `MSR_REG_LO:   rd_w = snap_ok_q ? snap_q[31:0] : lo_w;
      default:       rd_w = 32'h0000_0000;
    endcase
  end

  // Byte loader is shared by address ack and master ack
  always_comb begin
    st_d = st_q; bc_d = bc_q; bi_d = bi_q; sh_d = sh_q; tx_d = tx_q;
    ptr_d = ptr_q; wb_d = wb_q; oe_d = oe_q; rd_d = rd_q; nak_d = nak_q;
    commit = 1'b0; cap = 1'b0; snap_ok_d = snap_ok_q;
    if (start) begin
      st_d = msr_pkg::I_ADDR; bc_d = 4'h0; oe_d = 1'b0; snap_ok_d = 1'b0;
    end else if (stop) begin
      st_d = msr_pkg::I_IDLE; oe_d = 1'b0;
    end else if (rise) begin
      if (st_q == msr_pkg::I_ADDR || st_q == msr_pkg::I_REG ||
          st_q == msr_pkg::I_WR) begin
        sh_d = {sh_q[6:0], sda_f_q};
        bc_d = bc_q + 4'h1;
      end
      if (st_q == msr_pkg::I_MACK) nak_d = sda_f_q;
    end else if (fall) begin
      unique case (st_q)
        msr_pkg::I_ADDR: if (bc_q == 4'h8) begin
          if (sh_q[7:1] == DEV_ADDR) begin
            st_d = msr_pkg::I_AACK; oe_d = 1'b1; rd_d = sh_q[0];
          end else st_d = msr_pkg::I_IDLE;
        end
        msr_pkg::I_REG: if (bc_q == 4'h8) begin
          st_d = msr_pkg::I_RACK; oe_d = 1'b1; ptr_d = sh_q; bi_d = 2'h0;
        end
        msr_pkg::I_WR: if (bc_q == 4'h8) begin
          st_d = msr_pkg::I_WACK; oe_d = 1'b1; wb_d = {wb_q[23:0], sh_q};
          commit = (bi_q == 2'h3);
        end
        msr_pkg::I_RACK: begin
          st_d = msr_pkg::I_WR; oe_d = 1'b0; bc_d = 4'h0;
        end
        msr_pkg::I_WACK: begin
          st_d = msr_pkg::I_WR; oe_d = 1'b0; bc_d = 4'h0; bi_d = bi_q + 2'h1;
          if (bi_q == 2'h3) ptr_d = nxt_ptr(ptr_q, ctrl_q[`MSR_F_LOOP]);
        end
        msr_pkg::I_RD: if (bc_q == 4'h8) begin
          st_d = msr_pkg::I_MACK; oe_d = 1'b0;
        end else begin
          tx_d = {tx_q[6:0], 1'b0}; oe_d = ~tx_q[6]; bc_d = bc_q + 4'h1;
        end
        msr_pkg::I_AACK, msr_pkg::I_MACK: begin
          if (st_q == msr_pkg::I_AACK && !rd_q) begin
            st_d = msr_pkg::I_REG; oe_d = 1'b0; bc_d = 4'h0;
          end else if (st_q == msr_pkg::I_MACK && nak_q) begin
            st_d = msr_pkg::I_IDLE; oe_d = 1'b0;
          end else begin
            tx_d = rd_w[8'(31 - 8 * int'(bi_q)) -: 8];
            oe_d = ~tx_d[7]; st_d = msr_pkg::I_RD; bc_d = 4'h1;
            bi_d = bi_q + 2'h1;
            // R12 snapshot both words at start of upper word
            if (ptr_q == `MSR_REG_UP && bi_q == 2'h0) begin
              cap = 1'b1; snap_ok_d = 1'b1;
            end
            if (bi_q == 2'h3) ptr_d = nxt_ptr(ptr_q, ctrl_q[`MSR_F_LOOP]);
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_q <= msr_pkg::I_IDLE; bc_q <= 4'h0; bi_q <= 2'h0;
      sh_q <= 8'h00; tx_q <= 8'h00; ptr_q <= 8'h00; wb_q <= 32'h0000_0000;
      oe_q <= 1'b0; rd_q <= 1'b0; nak_q <= 1'b0; snap_ok_q <= 1'b0;
    end else begin
      st_q <= st_d; bc_q <= bc_d; bi_q <= bi_d; sh_q <= sh_d; tx_q <= tx_d;
      ptr_q <= ptr_d; wb_q <= wb_d; oe_q <= oe_d; rd_q <= rd_d;
      nak_q <= nak_d; snap_ok_q <= snap_ok_d;
    end
  end

  assign SDA_O  = 1'b0;
  assign SDA_OE = oe_q;
  assign wr_w   = {wb_q[23:0], sh_q};
  // R2 writes gated by access mode, except the mode field
  assign wr_ctrl = commit && ptr_q == `MSR_REG_CTRL;
  // R7 write one to clear the latch
  assign w1c = commit && CUST_ACCESS && ptr_q == `MSR_REG_UP && wr_w[`MSR_B_INT];

  // ==========================================
  // Data and flag registers
  always_comb begin
    ctrl_d = ctrl_q; x_d = x_q; y_d = y_q; z_d = z_q; hall_d = hall_q;
    t_d = t_q; snap_d = snap_q;
    // R2 mode field writable without access; R3 R4 need it
    if (wr_ctrl) begin
      ctrl_d[`MSR_F_MODE] = wr_w[1:0];
      if (CUST_ACCESS) ctrl_d = wr_w[6:0];
    end
    // R17 no updates while asleep
    if (SAMPLE_VLD && !frozen) begin
      x_d = X_IN; y_d = Y_IN; z_d = Z_IN; hall_d = HALL_IN;
    end
    if (TEMP_VLD && !frozen) t_d = TEMP_IN;
    if (cap) snap_d = {up_w, lo_w};
    // R6 set wins over clear on read
    new_d = (SAMPLE_VLD && !frozen) | (new_q & ~cap);
    // R7 R21 latched flag holds until write one
    int_d = THRESH_HIT | (INT_LATCH_EN & int_q & ~w1c);
    // R8 busy from event until write done
    wip_d = (THRESH_HIT & ~hit_p_q & INT_EE_EN) | (wip_q & ~EE_DONE);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl_q <= `MSR_CTRL_RST; x_q <= 12'h000; y_q <= 12'h000;
      z_q <= 12'h000; t_q <= 12'h000; hall_q <= 2'h0;
      snap_q <= 64'h0; new_q <= 1'b0; int_q <= 1'b0;
      wip_q <= 1'b0; hit_p_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d; x_q <= x_d; y_q <= y_d; z_q <= z_d; t_q <= t_d;
      hall_q <= hall_d; snap_q <= snap_d; new_q <= new_d; int_q <= int_d;
      wip_q <= wip_d; hit_p_q <= THRESH_HIT;
    end
  end

  assign INT_N = ~int_q;
  // NVM write kick as the busy flag rises
  assign EE_WR = wip_d & ~wip_q;

  // ==========================================
  // Measurement sequencer
  msr_pkg::msr_seq_t sq_q, sq_d;
  logic [31:0] cnt_q, cnt_d, tc_q, tc_d;
  logic [3:0]  lpc_q, lpc_d;
  logic        lp_temp;

  // Updates stop with the sequencer, so a reply already in flight still lands
  assign frozen = (sq_q == msr_pkg::SQ_SLEEP);

  // R20 inactive time in microseconds
  function automatic logic [31:0] inact_us(input logic [2:0] s);
    unique case (s)
      3'h0: inact_us = 32'h0000_01F4;
      3'h1: inact_us = 32'h0000_03E8;
      3'h2: inact_us = 32'h0000_1388;
      3'h3: inact_us = 32'h0000_2710;
      3'h4: inact_us = 32'h0000_C350;
      3'h5: inact_us = 32'h0001_86A0;
      3'h6: inact_us = 32'h0007_A120;
      default: inact_us = 32'h000F_4240;
    endcase
  endfunction

  // Long waits count up and compare; one counter serves the power-on and inactive waits
  always_comb begin
    sq_d = sq_q; cnt_d = cnt_q + 32'h1; lpc_d = lpc_q; lp_temp = 1'b0;
    unique case (sq_q)
      // R18 sleep exit pays the power-on delay
      msr_pkg::SQ_POD: if (cnt_q >= 32'(POD_CYC - 1)) sq_d = msr_pkg::SQ_MEAS;
      msr_pkg::SQ_MEAS: begin
        sq_d = msr_pkg::SQ_WAIT;
        // R15 one temperature per ten duty cycles
        if (duty) begin
          lpc_d = (lpc_q == `MSR_LP_TDIV - 4'h1) ? 4'h0 : lpc_q + 4'h1;
          lp_temp = (lpc_q == 4'h0);
        end
      end
      msr_pkg::SQ_WAIT: if (SAMPLE_VLD) begin
        // R19 duty mode rests after each sample
        sq_d = duty ? msr_pkg::SQ_IDLE : msr_pkg::SQ_MEAS;
        cnt_d = 32'h0;
      end
      // R3 R20 inactive period from ctrl 6:4
      msr_pkg::SQ_IDLE:
        if (cnt_q >= 32'(inact_us(ctrl_q[`MSR_F_LPCNT]) * CYC_PER_US) - 32'h1)
          sq_d = msr_pkg::SQ_MEAS;
      msr_pkg::SQ_SLEEP: begin
        cnt_d = 32'h0;
        if (!sleep) sq_d = msr_pkg::SQ_POD;
      end
    endcase
    // R17 sleep halts measuring
    if (sleep) sq_d = msr_pkg::SQ_SLEEP;
    if (!duty) lpc_d = 4'h0;
    // R14 temperature every 8 ms outside duty and sleep modes
    tc_d = (tc_q >= 32'(TEMP_CYC - 1) || sleep || duty) ? 32'h0 : tc_q + 32'h1;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sq_q <= msr_pkg::SQ_POD; cnt_q <= 32'h0; tc_q <= 32'h0; lpc_q <= 4'h0;
    end else begin
      sq_q <= sq_d; cnt_q <= cnt_d; tc_q <= tc_d; lpc_q <= lpc_d;
    end
  end

  assign MEAS_REQ = (sq_q == msr_pkg::SQ_MEAS) && !sleep;
  assign TEMP_REQ = lp_temp ||
                    (!sleep && !duty && tc_q >= 32'(TEMP_CYC - 1));

  // ==========================================
  // Checks
  new_clr_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R6
    cap && !SAMPLE_VLD |=> !new_q) else $error("new flag not cleared");
  new_set_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R6
    SAMPLE_VLD && !frozen |=> new_q) else $error("new flag not set");
  int_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R21
    int_q && INT_LATCH_EN && !w1c |=> !INT_N) else $error("latch lost");
  sleep_frz_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R17
    sleep && $stable(ctrl_q) |=> $stable(x_q) && $stable(t_q))
    else $error("update in sleep");
  ctrl_grd_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R2
    wr_ctrl && !CUST_ACCESS |=> ctrl_q[6:2] == $past(ctrl_q[6:2]))
    else $error("guarded write taken");
  mode3_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R22
    ctrl_q[1:0] == 2'h3 && $stable(ctrl_q) |-> MODE == 2'h0 && sq_q != msr_pkg::SQ_SLEEP)
    else $error("mode 3 not active");
  wake_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R18
    sq_q == msr_pkg::SQ_SLEEP && !sleep |=> sq_q == msr_pkg::SQ_POD ##1
    !MEAS_REQ) else $error("wake without delay");
  snap_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R12
    cap |=> snap_q == {$past(up_w), $past(lo_w)} && snap_ok_q)
    else $error("snapshot mismatch");
  wip_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R8
    wip_q && EE_DONE && !THRESH_HIT |=> !wip_q) else $error("busy stuck");

endmodule // msr_readout
`default_nettype wire

// *** dv/msr_i2c_host.sv ***
// Bus host model pacing two-wire transfers for the bench
`timescale 1ns/1ps
`default_nettype none
module msr_i2c_host (
  input  wire logic clk,    // Pacing clock
  output logic      scl,    // Bus clock, idles high
  output logic      sda_oe, // High pulls data low
  input  wire logic sda     // Resolved data line
);
  // ==========================================
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Wait whole core cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One 48 ns bit; data moves mid-low so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_oe <= ~b;
    cyc(3);
    scl <= 1'b1;
    cyc(3);
    r = sda;
    cyc(3);
    scl <= 1'b0;
    cyc(3);
  endtask
  // Start or repeated start
  task automatic start();
    sda_oe <= 1'b0;
    cyc(3);
    scl <= 1'b1;
    cyc(6);
    sda_oe <= 1'b1;
    cyc(6);
    scl <= 1'b0;
    cyc(3);
  endtask
  // Stop, leaves the bus idle
  task automatic stop();
    sda_oe <= 1'b1;
    cyc(3);
    scl <= 1'b1;
    cyc(6);
    sda_oe <= 1'b0;
    cyc(6);
  endtask
  // Byte out MSB first; acknowledge is low on the wire
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Byte in; host acknowledges all but the last
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule // msr_i2c_host
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the sensor readout block
`timescale 1ns/1ps
`default_nettype none
`include "msr_map.svh"
module tb;
  logic        clk, rst, scl, h_oe, d_oe, d_o, acc, lat, eee, hit, ee_done, ee_wr, int_n;
  logic        meas_req, s_vld, temp_req, t_vld, sda;
  logic [11:0] x_in, y_in, z_in, t_in;
  logic [1:0]  hall, mode;
  logic [31:0] rng, seen;
  logic [31:0] exp_q[$];
  event        word_ev;
  int          bad_count, tests_run, n_meas, n_temp, n_ee, cyc_n, t0, m0;
  // Open-drain data line with pull-up
  assign sda = ~h_oe & ~(d_oe & ~d_o);
  msr_readout #(.CYC_PER_US(1), .TEMP_CYC(100), .POD_CYC(50)) i_msr_readout (
    .CORE_CLK(clk), .RST(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(d_o), .SDA_OE(d_oe),
    .CUST_ACCESS(acc), .INT_LATCH_EN(lat), .INT_EE_EN(eee), .THRESH_HIT(hit),
    .EE_DONE(ee_done), .EE_WR(ee_wr), .INT_N(int_n), .MEAS_REQ(meas_req),
    .SAMPLE_VLD(s_vld), .X_IN(x_in), .Y_IN(y_in), .Z_IN(z_in), .HALL_IN(hall),
    .TEMP_REQ(temp_req), .TEMP_VLD(t_vld), .TEMP_IN(t_in), .MODE(mode));
  msr_i2c_host i_msr_i2c_host (.clk(clk), .scl(scl), .sda_oe(h_oe), .sda(sda));
  // ==========================================
  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Sensor front end: answers each request one cycle later with fresh random data
  always @(posedge clk) begin
    s_vld <= meas_req;
    t_vld <= temp_req;
    cyc_n <= cyc_n + 1;
    n_meas <= n_meas + int'(meas_req);
    n_temp <= n_temp + int'(temp_req);
    n_ee <= n_ee + int'(ee_wr);
    rng <= xs(rng);
    if (meas_req) begin
      {x_in, y_in} <= {rng[23:0]};
      z_in <= {rng[31:24], rng[3:0]};
      hall <= (rng[5:4] == 2'd3) ? 2'd2 : rng[5:4];
    end
    if (temp_req) t_in <= rng[27:16];
  end
  // ==========================================
  // Compare and report
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Scoreboard: oldest expected word against each word read back
  initial forever begin
    @(word_ev);
    check("read word", exp_q.pop_front(), seen);
  end
  // Bounded wait on the request counters
  task automatic await(input bit tmp, input int tgt, input int lim);
    int i;
    i = 0;
    while ((tmp ? n_temp : n_meas) < tgt && i < lim) begin
      @(posedge clk);
      i++;
    end
    check("request seen", 1, {31'b0, (tmp ? n_temp : n_meas) >= tgt});
  endtask
  function automatic logic [31:0] up_w(input logic nd, input logic it);
    return {x_in[11:4], y_in[11:4], z_in[11:4], nd, it, t_in[11:6]};
  endfunction
  function automatic logic [31:0] lo_w(input logic wip);
    return {11'h000, wip, x_in[3:0], y_in[3:0], z_in[3:0], hall, t_in[5:0]};
  endfunction
  // ==========================================
  // Register access over the bus, 4 bytes per word MSB first
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic k;
    i_msr_i2c_host.start();
    i_msr_i2c_host.tx(8'hC0, k);
    check("address ack", 1, {31'b0, k});
    i_msr_i2c_host.tx(a, k);
    for (int i = 3; i >= 0; i--) i_msr_i2c_host.tx(d[8*i +: 8], k);
    i_msr_i2c_host.stop();
  endtask
  task automatic rd_regs(input logic [7:0] a, input int nw);
    logic k;
    logic [31:0] w;
    i_msr_i2c_host.start();
    i_msr_i2c_host.tx(8'hC0, k);
    i_msr_i2c_host.tx(a, k);
    i_msr_i2c_host.start();
    i_msr_i2c_host.tx(8'hC1, k);
    for (int j = 0; j < nw; j++) begin
      for (int i = 3; i >= 0; i--) i_msr_i2c_host.rx(j == nw - 1 && i == 0, w[8*i +: 8]);
      seen = w;
      -> word_ev;
    end
    i_msr_i2c_host.stop();
  endtask
  // Hang guard
  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    results();
  end
  // ==========================================
  // Main sequence
  initial begin
    {rst, acc, lat, eee, hit, ee_done, s_vld, t_vld} = 8'h80;
    {x_in, y_in, z_in, t_in, hall} = 50'h0;
    {cyc_n, n_meas, n_temp, n_ee, bad_count, tests_run} = 192'h0;
    rng = 32'ha08c_2578;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t0 = cyc_n;
    await(0, 1, 300);
    check("power-on wait", 1, {31'b0, cyc_n - t0 >= 50 && cyc_n - t0 <= 56}); // delay
    await(1, n_temp + 1, 500);
    t0 = cyc_n;
    await(1, n_temp + 1, 500);
    check("temp period", 1, {31'b0, cyc_n - t0 >= 100 && cyc_n - t0 <= 130}); // refresh
    wr_reg(`MSR_REG_CTRL, 32'hFFFF_FFFD); // only mode taken
    repeat (50) @(posedge clk);
    check("mode", 32'h1, {30'b0, mode}); // sleep selected
    m0 = n_meas;
    repeat (400) @(posedge clk);
    check("sleep updates", m0, n_meas); // no updates
    exp_q.push_back(32'h0000_0001);
    rd_regs(`MSR_REG_CTRL, 1); // read without access
    exp_q.push_back(up_w(1'b1, 1'b0));
    exp_q.push_back(lo_w(1'b0));
    rd_regs(`MSR_REG_UP, 2); // burst of 8 bytes
    exp_q.push_back(up_w(1'b0, 1'b0));
    rd_regs(`MSR_REG_UP, 1); // cleared by read
    lat <= 1'b1;
    eee <= 1'b1;
    hit <= 1'b1;
    @(posedge clk);
    hit <= 1'b0;
    repeat (30) @(posedge clk);
    check("int out", 32'h0, {31'b0, int_n}); // held after event
    check("nvm start", 32'h1, n_ee); // write started
    exp_q.push_back(up_w(1'b0, 1'b1));
    exp_q.push_back(lo_w(1'b1));
    rd_regs(`MSR_REG_UP, 2); // flags set
    wr_reg(`MSR_REG_UP, 32'h0000_0040);
    check("w1c no access", 32'h0, {31'b0, int_n}); // clear refused
    ee_done <= 1'b1;
    acc <= 1'b1;
    @(posedge clk);
    ee_done <= 1'b0;
    wr_reg(`MSR_REG_UP, 32'h0000_0040);
    check("w1c", 32'h1, {31'b0, int_n}); // write one clears
    exp_q.push_back(up_w(1'b0, 1'b0));
    exp_q.push_back(lo_w(1'b0));
    rd_regs(`MSR_REG_UP, 2); // busy cleared
    wr_reg(`MSR_REG_CTRL, 32'hFFFF_FFBD);
    exp_q.push_back(32'h0000_003D);
    rd_regs(`MSR_REG_CTRL, 1); // fields held
    exp_q.push_back(up_w(1'b0, 1'b0));
    exp_q.push_back(lo_w(1'b0));
    exp_q.push_back(up_w(1'b0, 1'b0));
    rd_regs(`MSR_REG_UP, 3); // loop folds back to upper word
    wr_reg(`MSR_REG_CTRL, 32'h0000_0003);
    t0 = cyc_n;
    await(0, n_meas + 1, 400);
    check("wake wait", 1, {31'b0, cyc_n - t0 >= 20 && cyc_n - t0 <= 60}); // wake delay
    check("mode 3", 32'h0, {30'b0, mode}); // acts active
    for (int lp = 2; lp >= 0; lp--) begin
      wr_reg(`MSR_REG_CTRL, {25'h0, lp[2:0], 4'h2});
      await(0, n_meas + 1, 6000);
      t0 = cyc_n;
      await(0, n_meas + 1, 6000);
      m0 = (lp == 2) ? 5000 : (lp == 1) ? 1000 : 500;
      check("inactive", 1, {31'b0, cyc_n - t0 >= m0 && cyc_n - t0 <= m0 + 60});
    end
    m0 = n_meas;
    t0 = n_temp;
    await(0, m0 + 20, 15000);
    check("duty temp", 32'h2, n_temp - t0); // one per ten
    results();
  end
endmodule // tb
`default_nettype wire
